/* dv/rx_framer_status_regs_bench.sv */
// Self-checking bench for the receive framer status register bank
`timescale 1ns/1ps
`default_nettype none

module rx_framer_status_regs_bench;
    import rxfs_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary value
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic [6:0] ev = 7'h00;
    logic [1:0] bv = 2'h0;
    logic [1:0] bf = 2'h0;
    logic [1:0] bb = 2'h0;
    logic [4:0] chan_num = 5'h00;
    logic [5:0] boc_code = 6'h00;
    logic [2:0] srch = 3'h0;
    logic [10:0] slc_c = 11'h000;
    logic [2:0] slc_m = 3'h0;
    logic [1:0] slc_a = 2'h0;
    logic [3:0] slc_s = 4'h0;
    logic [3:0] ts0_frame = 4'h0;
    logic [7:0] ts0_byte = 8'h00;
    logic [7:0] last_rd;
    logic [2:0] ctl_out;
    logic [7:0] idle_addr [10] = '{ADDR_OOS_HIGH, ADDR_OOS_LOW, ADDR_EBIT_HIGH,
        ADDR_EBIT_LOW, ADDR_MON_BYTE, ADDR_LINK_STATUS, ADDR_BOC, ADDR_CAPTURE_ONE,
        ADDR_CAPTURE_TWO, ADDR_CAPTURE_THREE};
    int err_total = 0;
    int tests_run = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    rxfs_regs #(.MF_SEARCH_LEN(16), .FW_REVISION(REV)) rxfs_regs_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .out_of_sync_event(ev[0]), .ebit_event(ev[1]), .chan_bit_valid(bv[0]),
        .chan_bit_first(bf[0]), .chan_num(chan_num), .chan_bit(bb[0]),
        .link_bit_valid(bv[1]), .link_bit_first(bf[1]), .link_bit(bb[1]),
        .link_mf_boundary(ev[2]), .boc_valid(ev[3]), .boc_code(boc_code),
        .crc_mf_search_active(srch[2]), .signaling_mf_search_active(srch[1]),
        .frame_search_active(srch[0]), .crc_mf_sync(ev[4]), .slc_valid(ev[5]),
        .slc_c_bits(slc_c), .slc_m_bits(slc_m), .slc_a_bits(slc_a), .slc_s_bits(slc_s),
        .ts0_valid(ev[6]), .ts0_frame(ts0_frame), .ts0_byte(ts0_byte),
        .e1_mode(ctl_out[0]), .crc_mode_enable(ctl_out[1]),
        .receiver_soft_reset(ctl_out[2])
    );

    rxfs_host rxfs_host_inst (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // Verdict and end of run, reached from the main sequence or the watchdog
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        rxfs_host_inst.rd(a, last_rd);
        cmp(last_rd, exp);
    endtask

    // One-cycle pulse on a datapath strobe
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'h1;
        @(posedge clk);
        ev[i] <= 1'h0;
    endtask

    // Serial bits: monitor byte sent msb first, link bits lsb first
    task automatic ser(input int k, input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            bv[k] <= 1'h1;
            bf[k] <= (i == 0);
            bb[k] <= (k == 0) ? v[7 - i] : v[i];
        end
        @(posedge clk);
        bv[k] <= 1'h0;
        bf[k] <= 1'h0;
    endtask

    task automatic ts0(input logic [3:0] f, input logic [7:0] b);
        ts0_frame <= f;
        ts0_byte <= b;
        pulse(6);
    endtask

    // Main sequence: T1 captures first, then E1 and the search counter
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        foreach (idle_addr[i]) chk(idle_addr[i], 8'h00);
        chk(ADDR_FW_REV, REV);
        rxfs_host_inst.wr(ADDR_FW_REV, 8'hFF);
        chk(ADDR_FW_REV, REV);
        rxfs_host_inst.wr(ADDR_OOS_LOW, 8'hFF);
        chk(ADDR_OOS_LOW, 8'h00);
        chk(8'h70, 8'h00);
        repeat (3) pulse(0);
        pulse(1);
        chk(ADDR_OOS_HIGH, 8'h00);
        chk(ADDR_OOS_LOW, 8'h03);
        chk(ADDR_EBIT_LOW, 8'h00);
        rxfs_host_inst.wr(ADDR_MON_SELECT, 8'h05);
        chan_num <= 5'h03;
        ser(0, 8'h11, 8);
        chan_num <= 5'h05;
        ser(0, 8'hA6, 8);
        chk(ADDR_MON_BYTE, 8'hA6);
        ser(1, 8'h35, 8);
        chk(ADDR_LINK_STATUS, 8'h35);
        rxfs_host_inst.wr(ADDR_RX_CTRL, 8'h02);
        ser(1, 8'h2D, 6);
        chk(ADDR_LINK_STATUS, 8'h35);
        pulse(2);
        chk(ADDR_LINK_STATUS, 8'h2D);
        boc_code <= 6'h2B;
        pulse(3);
        chk(ADDR_BOC, 8'h2B);
        slc_c <= 11'h5A3;
        slc_m <= 3'h5;
        slc_a <= 2'h2;
        slc_s <= 4'h6;
        pulse(5);
        chk(ADDR_CAPTURE_ONE, 8'hA3);
        chk(ADDR_CAPTURE_TWO, 8'h55);
        chk(ADDR_CAPTURE_THREE, 8'hB5);
        chk(ADDR_SI_ODD, 8'h00);
        // E1 line: 0x62 turns into the live status byte
        rxfs_host_inst.wr(ADDR_RX_MODE, 8'h01);
        chk(ADDR_LINK_STATUS, 8'h00);
        cmp({5'h00, ctl_out}, 8'h01);
        repeat (2) pulse(1);
        chk(ADDR_EBIT_HIGH, 8'h00);
        chk(ADDR_EBIT_LOW, 8'h02);
        ts0(4'h0, 8'h9B);
        ts0(4'h1, 8'h5F);
        chk(ADDR_CAPTURE_ONE, 8'h9B);
        chk(ADDR_CAPTURE_TWO, 8'h5F);
        // Frame 15 is a non-align frame too, so it replaces the byte above
        ts0(4'hF, 8'h80);
        chk(ADDR_CAPTURE_TWO, 8'h80);
        chk(ADDR_CAPTURE_THREE, 8'h01);
        chk(ADDR_SI_ODD, 8'h80);
        srch <= 3'h1;
        chk(ADDR_LINK_STATUS, 8'h01);
        srch <= 3'h2;
        chk(ADDR_LINK_STATUS, 8'h02);
        // Search timer shortened to 16 cycles; waits sit mid-period for margin
        srch <= 3'h0;
        rxfs_host_inst.wr(ADDR_RX_CTRL, 8'h01);
        srch <= 3'h4;
        repeat (88) @(posedge clk);
        chk(ADDR_LINK_STATUS, 8'h1C);
        cmp({5'h00, ctl_out}, 8'h03);
        repeat (1100) @(posedge clk);
        chk(ADDR_LINK_STATUS, 8'hFC);
        cmp({7'h00, rxfs_host_inst.overdue(last_rd)}, 8'h01);
        srch <= 3'h0;
        pulse(4);
        chk(ADDR_LINK_STATUS, 8'h00);
        srch <= 3'h4;
        repeat (56) @(posedge clk);
        chk(ADDR_LINK_STATUS, 8'h0C);
        rxfs_host_inst.wr(ADDR_RX_CTRL, 8'h00);
        chk(ADDR_LINK_STATUS, 8'h04);
        rxfs_host_inst.soft_reset(1'h1);
        chk(ADDR_OOS_LOW, 8'h00);
        cmp({5'h00, ctl_out}, 8'h05);
        chk(ADDR_CAPTURE_ONE, 8'h00);
        rxfs_host_inst.soft_reset(1'h0);
        pulse(0);
        chk(ADDR_OOS_LOW, 8'h01);
        cmp({5'h00, ctl_out}, 8'h01);
        print_verdict;
    end

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict;
    end
endmodule

`default_nettype wire

/* dv/rxfs_host.sv */
// Host processor model driving the byte-wide register port
`timescale 1ns/1ps
`default_nettype none

module rxfs_host
    import rxfs_pkg::*;
(
    input wire logic clk,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // About 400 ms of searching at 8 ms per search
    localparam int SEARCH_LIMIT = 50;

    // Bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end

    // One-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    // Read data taken mid-cycle while they stand; returns on a rising edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask

    // Level reset: raise, then lower; the line stays in E1 throughout
    task automatic soft_reset(input logic on);
        wr(ADDR_RX_MODE, {6'h00, on, 1'h1});
    endtask

    // Hidden count bit 1 makes this estimate err low by at most two searches
    function automatic logic overdue(input logic [7:0] s);
        return {s[7:4], 1'h0, s[3]} >= 6'(SEARCH_LIMIT);
    endfunction
endmodule

`default_nettype wire

/* src/rxfs_pkg.sv */
// Constants for the receive framer status and counter register bank
package rxfs_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_OOS_HIGH = 8'h54;
    localparam logic [7:0] ADDR_OOS_LOW = 8'h55;
    localparam logic [7:0] ADDR_EBIT_HIGH = 8'h56;
    localparam logic [7:0] ADDR_EBIT_LOW = 8'h57;
    localparam logic [7:0] ADDR_MON_BYTE = 8'h60;
    localparam logic [7:0] ADDR_FW_REV = 8'h61;
    localparam logic [7:0] ADDR_LINK_STATUS = 8'h62;
    localparam logic [7:0] ADDR_BOC = 8'h63;
    localparam logic [7:0] ADDR_CAPTURE_ONE = 8'h64;
    localparam logic [7:0] ADDR_CAPTURE_TWO = 8'h65;
    localparam logic [7:0] ADDR_CAPTURE_THREE = 8'h66;
    localparam logic [7:0] ADDR_SI_ODD = 8'h67;
    localparam logic [7:0] ADDR_RX_MODE = 8'h80;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h81;
    localparam logic [7:0] ADDR_MON_SELECT = 8'h82;

    // Field positions in the mode and control registers
    localparam int MODE_E1_BIT = 0;
    localparam int MODE_SOFT_RESET_BIT = 1;
    localparam int CTRL_CRC_ENABLE_BIT = 0;
    localparam int CTRL_D4_BIT = 1;

    // Values after reset, and counter saturation limits
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [5:0] MF_COUNT_RESET = 6'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [5:0] MF_COUNT_MAX = 6'h3F;

    // Position counts for serial captures
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // Multiframe search period and its length in clock cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int MF_SEARCH_TIME_NS = 8000000;
    localparam int MF_SEARCH_CYCLES = MF_SEARCH_TIME_NS / CLK_PERIOD_NS;
    localparam int MF_TIMER_W = 20;

    // Receiver state, cleared by device reset and by the receiver soft reset
    typedef struct packed {
        logic [15:0] oos_cnt;
        logic [15:0] ebit_cnt;
        logic [7:0] mon_shift;
        logic [2:0] mon_pos;
        logic [7:0] mon_byte;
        logic [7:0] dl_shift;
        logic [2:0] dl_pos;
        logic [5:0] fs_shift;
        logic [7:0] dl_byte;
        logic [5:0] boc;
        logic [5:0] mf_cnt;
        logic [MF_TIMER_W-1:0] mf_timer;
        logic [10:0] slc_c;
        logic [2:0] slc_m;
        logic [1:0] slc_a;
        logic [3:0] slc_s;
        logic slc_seen;
        logic [7:0] align_byte;
        logic [7:0] nonalign_byte;
        logic [7:0] si_even;
        logic [7:0] si_odd;
    } rxfs_rx_t;

    // Whole module state
    typedef struct packed {
        rxfs_rx_t rx;
        logic e1_mode;
        logic soft_reset;
        logic crc_enable;
        logic d4_framing;
        logic [4:0] mon_select;
        logic [7:0] rdata;
    } rxfs_state_t;

endpackage

/* src/rxfs_regs.sv */
// Receive framer status, counter and capture register bank
//
// Operation
// - 16-bit out-of-sync count, high and low bytes
// - E1-only 16-bit E-bit count at 0x56/0x57
// - Monitor byte, first bit in bit 7
// - Read-only firmware revision at 0x61
// - 0x62 muxed by line mode
// - T1 data link byte, first bit in bit 0
// - D4 Fs bits 0..5, multiframe boundary update
// - Last valid six-bit code, upper bits zero
// - E1 status byte is live, not latched
// - Search counter increments per 8 ms timeout
// - Search counter cleared on multiframe sync
// - Search counter cleared when mode disabled
// - Six-bit search counter saturates
// - Status shows counter bits 5..2 and 0
// - Bits 2..0 show active search levels
// - T1 SLC-96 fields at 0x64..0x66
// - E1 align frame byte at 0x64
// - E1 non-align frame byte at 0x65
// - Even frame Si bits at 0x66
// - Odd frame Si bits at 0x67
// - Soft reset bit holds receiver in reset
`timescale 1ns/1ps
`default_nettype none

module rxfs_regs
    import rxfs_pkg::*;
#(
    parameter int MF_SEARCH_LEN = MF_SEARCH_CYCLES,
    parameter logic [7:0] FW_REVISION = 8'h01 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic out_of_sync_event,
    input wire logic ebit_event,
    input wire logic chan_bit_valid,
    input wire logic chan_bit_first,
    input wire logic [4:0] chan_num,
    input wire logic chan_bit,
    input wire logic link_bit_valid,
    input wire logic link_bit_first,
    input wire logic link_bit,
    input wire logic link_mf_boundary,
    input wire logic boc_valid,
    input wire logic [5:0] boc_code,
    input wire logic crc_mf_search_active,
    input wire logic signaling_mf_search_active,
    input wire logic frame_search_active,
    input wire logic crc_mf_sync,
    input wire logic slc_valid,
    input wire logic [10:0] slc_c_bits,
    input wire logic [2:0] slc_m_bits,
    input wire logic [1:0] slc_a_bits,
    input wire logic [3:0] slc_s_bits,
    input wire logic ts0_valid,
    input wire logic [3:0] ts0_frame,
    input wire logic [7:0] ts0_byte,
    output logic e1_mode,
    output logic crc_mode_enable,
    output logic receiver_soft_reset
);

    localparam logic [MF_TIMER_W-1:0] MF_LAST = MF_TIMER_W'(MF_SEARCH_LEN - 1);

    rxfs_state_t s_q;
    rxfs_state_t s_d;
    logic [7:0] live_status;
    logic [2:0] mon_idx;
    logic [2:0] dl_idx;
    logic timer_run;
    logic mf_clr_wr;

    // Live E1 status byte, sampled only when a read is taken
    assign live_status = {s_q.rx.mf_cnt[5:2], s_q.rx.mf_cnt[0], crc_mf_search_active,
                          signaling_mf_search_active, frame_search_active};

    assign mon_idx = chan_bit_first ? 3'h0 : s_q.rx.mon_pos;
    assign dl_idx = link_bit_first ? 3'h0 : s_q.rx.dl_pos;
    assign timer_run = s_q.e1_mode && s_q.crc_enable && crc_mf_search_active;
    assign mf_clr_wr = reg_wr && reg_addr == ADDR_RX_CTRL && !reg_wdata[CTRL_CRC_ENABLE_BIT];

    // Next state of the whole bank
    always_comb begin
        s_d = s_q;

        // Frame loss count; saturates so a long outage never reads as few
        if (out_of_sync_event && s_q.rx.oos_cnt != COUNT_MAX) begin
            s_d.rx.oos_cnt = s_q.rx.oos_cnt + 16'h0001;
        end

        // E-bit errors only count on an E1 line
        if (ebit_event && s_q.e1_mode && s_q.rx.ebit_cnt != COUNT_MAX) begin
            s_d.rx.ebit_cnt = s_q.rx.ebit_cnt + 16'h0001;
        end

        // Channel monitor shifts left so the first bit lands in bit 7
        if (chan_bit_valid && chan_num == s_q.mon_select) begin
            s_d.rx.mon_shift = {s_q.rx.mon_shift[6:0], chan_bit};
            s_d.rx.mon_pos = mon_idx + 3'h1;
            if (mon_idx == BYTE_LAST_BIT) begin
                s_d.rx.mon_byte = {s_q.rx.mon_shift[6:0], chan_bit};
            end
        end

        // Data link shifts right so the first bit lands in bit 0
        if (link_bit_valid && !s_q.e1_mode) begin
            s_d.rx.dl_shift = {link_bit, s_q.rx.dl_shift[7:1]};
            s_d.rx.fs_shift = {link_bit, s_q.rx.fs_shift[5:1]};
            s_d.rx.dl_pos = dl_idx + 3'h1;
            if (!s_q.d4_framing && dl_idx == BYTE_LAST_BIT) begin
                s_d.rx.dl_byte = {link_bit, s_q.rx.dl_shift[7:1]};
            end
        end

        // D4 Fs bits only publish at a multiframe edge
        if (link_mf_boundary && s_q.d4_framing && !s_q.e1_mode) begin
            s_d.rx.dl_byte = {2'b00, s_q.rx.fs_shift};
        end

        // Hold the last valid code until a new one arrives
        if (boc_valid && !s_q.e1_mode) begin
            s_d.rx.boc = boc_code;
        end

        // Search period timer; restarts at each expiry
        if (timer_run) begin
            if (s_q.rx.mf_timer == MF_LAST) begin
                s_d.rx.mf_timer = '0;
                if (s_q.rx.mf_cnt != MF_COUNT_MAX) begin
                    s_d.rx.mf_cnt = s_q.rx.mf_cnt + 6'h01;
                end
            end else begin
                s_d.rx.mf_timer = s_q.rx.mf_timer + MF_TIMER_W'(1);
            end
        end else begin
            s_d.rx.mf_timer = '0;
        end

        // Sync or a disable write wins over a same-cycle timeout
        if (crc_mf_sync) begin
            s_d.rx.mf_cnt = MF_COUNT_RESET;
        end
        if (mf_clr_wr) begin
            s_d.rx.mf_cnt = MF_COUNT_RESET;
        end

        // SLC-96 data link fields
        if (slc_valid && !s_q.e1_mode) begin
            s_d.rx.slc_c = slc_c_bits;
            s_d.rx.slc_m = slc_m_bits;
            s_d.rx.slc_a = slc_a_bits;
            s_d.rx.slc_s = slc_s_bits;
            s_d.rx.slc_seen = 1'b1;
        end

        // Timeslot 0 captures; even frames carry alignment
        if (ts0_valid && s_q.e1_mode) begin
            if (!ts0_frame[0]) begin
                s_d.rx.align_byte = ts0_byte;
                s_d.rx.si_even[ts0_frame[3:1]] = ts0_byte[7];
            end else begin
                s_d.rx.nonalign_byte = ts0_byte;
                s_d.rx.si_odd[ts0_frame[3:1]] = ts0_byte[7];
            end
        end

        // Software writes; read-only offsets fall through untouched
        if (reg_wr) begin
            if (reg_addr == ADDR_RX_MODE) begin
                s_d.e1_mode = reg_wdata[MODE_E1_BIT];
                s_d.soft_reset = reg_wdata[MODE_SOFT_RESET_BIT];
            end else if (reg_addr == ADDR_RX_CTRL) begin
                s_d.crc_enable = reg_wdata[CTRL_CRC_ENABLE_BIT];
                s_d.d4_framing = reg_wdata[CTRL_D4_BIT];
            end else if (reg_addr == ADDR_MON_SELECT) begin
                s_d.mon_select = reg_wdata[4:0];
            end
        end

        // Receiver held cleared while soft reset stays high
        if (s_q.soft_reset) begin
            s_d.rx = '0;
        end

        // Read data lives only in the cycle after the read strobe
        s_d.rdata = BYTE_RESET;
        if (reg_rd) begin
            if (reg_addr == ADDR_OOS_HIGH) begin
                s_d.rdata = s_q.rx.oos_cnt[15:8];
            end else if (reg_addr == ADDR_OOS_LOW) begin
                s_d.rdata = s_q.rx.oos_cnt[7:0];
            end else if (reg_addr == ADDR_EBIT_HIGH) begin
                s_d.rdata = s_q.rx.ebit_cnt[15:8];
            end else if (reg_addr == ADDR_EBIT_LOW) begin
                s_d.rdata = s_q.rx.ebit_cnt[7:0];
            end else if (reg_addr == ADDR_MON_BYTE) begin
                s_d.rdata = s_q.rx.mon_byte;
            end else if (reg_addr == ADDR_FW_REV) begin
                s_d.rdata = FW_REVISION;
            end else if (reg_addr == ADDR_LINK_STATUS) begin
                s_d.rdata = s_q.e1_mode ? live_status : s_q.rx.dl_byte;
            end else if (reg_addr == ADDR_BOC) begin
                s_d.rdata = {2'b00, s_q.rx.boc};
            end else if (reg_addr == ADDR_CAPTURE_ONE) begin
                s_d.rdata = s_q.e1_mode ? s_q.rx.align_byte : s_q.rx.slc_c[7:0];
            end else if (reg_addr == ADDR_CAPTURE_TWO) begin
                // Spoiler bits stay zero until the first link frame lands
                s_d.rdata = s_q.e1_mode ? s_q.rx.nonalign_byte
                          : {s_q.rx.slc_m[1:0], 1'b0, s_q.rx.slc_seen, 1'b0,
                             s_q.rx.slc_c[10:8]};
            end else if (reg_addr == ADDR_CAPTURE_THREE) begin
                s_d.rdata = s_q.e1_mode ? s_q.rx.si_even
                          : {s_q.rx.slc_seen, s_q.rx.slc_s, s_q.rx.slc_a,
                             s_q.rx.slc_m[2]};
            end else if (reg_addr == ADDR_SI_ODD) begin
                s_d.rdata = s_q.e1_mode ? s_q.rx.si_odd : BYTE_RESET;
            end else if (reg_addr == ADDR_RX_MODE) begin
                s_d.rdata = {6'h00, s_q.soft_reset, s_q.e1_mode};
            end else if (reg_addr == ADDR_RX_CTRL) begin
                s_d.rdata = {6'h00, s_q.d4_framing, s_q.crc_enable};
            end else if (reg_addr == ADDR_MON_SELECT) begin
                s_d.rdata = {3'h0, s_q.mon_select};
            end
        end
    end

    // State register; everything starts at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign e1_mode = s_q.e1_mode;
    assign crc_mode_enable = s_q.crc_enable;
    assign receiver_soft_reset = s_q.soft_reset;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    oos_count_step_a:
    assert property (out_of_sync_event && !s_q.soft_reset && s_q.rx.oos_cnt != COUNT_MAX
                     |=> s_q.rx.oos_cnt == $past(s_q.rx.oos_cnt) + 16'h0001)
        else $error("frame loss count did not step");

    ebit_t1_hold_a:
    assert property (!s_q.e1_mode && !s_q.soft_reset |=> $stable(s_q.rx.ebit_cnt))
        else $error("E-bit count moved in T1 mode");

    fw_rev_read_a:
    assert property (reg_rd && reg_addr == ADDR_FW_REV |=> reg_rdata == FW_REVISION)
        else $error("firmware revision read wrong");

    status_live_a:
    assert property (reg_rd && reg_addr == ADDR_LINK_STATUS && s_q.e1_mode
                     |=> reg_rdata[2:0] == $past({crc_mf_search_active,
                         signaling_mf_search_active, frame_search_active}))
        else $error("live status bits not current");

    boc_upper_zero_a:
    assert property (reg_rd && reg_addr == ADDR_BOC |=> reg_rdata[7:6] == 2'b00)
        else $error("code register upper bits set");

    mf_sync_clear_a:
    assert property (crc_mf_sync |=> s_q.rx.mf_cnt == MF_COUNT_RESET)
        else $error("search counter not cleared on sync");

    mf_disable_clear_a:
    assert property (mf_clr_wr |=> s_q.rx.mf_cnt == MF_COUNT_RESET)
        else $error("search counter not cleared on disable");

    mf_saturate_a:
    assert property (s_q.rx.mf_cnt == MF_COUNT_MAX && !crc_mf_sync && !mf_clr_wr
                     && !s_q.soft_reset |=> s_q.rx.mf_cnt == MF_COUNT_MAX)
        else $error("search counter wrapped");

    mf_timeout_a:
    assert property (timer_run && s_q.rx.mf_timer == MF_LAST && s_q.rx.mf_cnt != MF_COUNT_MAX
                     && !crc_mf_sync && !mf_clr_wr && !s_q.soft_reset
                     |=> s_q.rx.mf_cnt == $past(s_q.rx.mf_cnt) + 6'h01)
        else $error("search counter missed a timeout");

    soft_reset_hold_a:
    assert property (s_q.soft_reset [*2] |-> s_q.rx.oos_cnt == COUNT_RESET
                     && s_q.rx.mf_cnt == MF_COUNT_RESET)
        else $error("receiver not held in soft reset");

    // Counters move only on their own events, never on a register read
    oos_count_hold_a:
    assert property (!out_of_sync_event && !s_q.soft_reset |=> $stable(s_q.rx.oos_cnt))
        else $error("frame loss count moved without an event");

    oos_high_read_a:
    assert property (reg_rd && reg_addr == ADDR_OOS_HIGH
                     |=> reg_rdata == $past(s_q.rx.oos_cnt[15:8]))
        else $error("frame loss high byte read wrong");

    ebit_count_step_a:
    assert property (ebit_event && s_q.e1_mode && !s_q.soft_reset
                     && s_q.rx.ebit_cnt != COUNT_MAX
                     |=> s_q.rx.ebit_cnt == $past(s_q.rx.ebit_cnt) + 16'h0001)
        else $error("E-bit count did not step");

    // Serial captures keep arrival order: last bit at the far end of each byte
    mon_last_bit_a:
    assert property (chan_bit_valid && chan_num == s_q.mon_select && mon_idx == BYTE_LAST_BIT
                     && !s_q.soft_reset |=> s_q.rx.mon_byte[0] == $past(chan_bit))
        else $error("monitor byte lost its last bit");

    link_last_bit_a:
    assert property (link_bit_valid && !s_q.e1_mode && !s_q.d4_framing
                     && dl_idx == BYTE_LAST_BIT && !s_q.soft_reset
                     |=> s_q.rx.dl_byte[7] == $past(link_bit))
        else $error("data link byte lost its last bit");

    fs_publish_a:
    assert property (link_mf_boundary && s_q.d4_framing && !s_q.e1_mode && !s_q.soft_reset
                     |=> s_q.rx.dl_byte == {2'b00, $past(s_q.rx.fs_shift)})
        else $error("Fs bits not published at multiframe edge");

    fs_hold_a:
    assert property (s_q.d4_framing && !link_mf_boundary && !s_q.soft_reset
                     |=> $stable(s_q.rx.dl_byte))
        else $error("data link byte moved between multiframes");

    boc_capture_a:
    assert property (boc_valid && !s_q.e1_mode && !s_q.soft_reset
                     |=> s_q.rx.boc == $past(boc_code))
        else $error("bit-oriented code not captured");

    link_read_mux_a:
    assert property (reg_rd && reg_addr == ADDR_LINK_STATUS && !s_q.e1_mode
                     |=> reg_rdata == $past(s_q.rx.dl_byte))
        else $error("T1 read of shared offset wrong");

    status_count_bits_a:
    assert property (reg_rd && reg_addr == ADDR_LINK_STATUS && s_q.e1_mode
                     |=> reg_rdata[7:3] == $past({s_q.rx.mf_cnt[5:2], s_q.rx.mf_cnt[0]}))
        else $error("status byte count bits wrong");

    // Timeslot 0 captures follow the frame parity
    align_capture_a:
    assert property (ts0_valid && s_q.e1_mode && !ts0_frame[0] && !s_q.soft_reset
                     |=> s_q.rx.align_byte == $past(ts0_byte))
        else $error("align frame byte not captured");

    nonalign_capture_a:
    assert property (ts0_valid && s_q.e1_mode && ts0_frame[0] && !s_q.soft_reset
                     |=> s_q.rx.nonalign_byte == $past(ts0_byte))
        else $error("non-align frame byte not captured");

    si_even_bit_a:
    assert property (ts0_valid && s_q.e1_mode && !ts0_frame[0] && !s_q.soft_reset
                     |=> s_q.rx.si_even[$past(ts0_frame[3:1])] == $past(ts0_byte[7]))
        else $error("even frame Si bit misplaced");

    si_odd_bit_a:
    assert property (ts0_valid && s_q.e1_mode && ts0_frame[0] && !s_q.soft_reset
                     |=> s_q.rx.si_odd[$past(ts0_frame[3:1])] == $past(ts0_byte[7]))
        else $error("odd frame Si bit misplaced");

    e1_capture_hold_a:
    assert property (!s_q.e1_mode && !s_q.soft_reset
                     |=> $stable(s_q.rx.align_byte) && $stable(s_q.rx.si_odd))
        else $error("E1 capture moved on a T1 line");

    slc_capture_a:
    assert property (slc_valid && !s_q.e1_mode && !s_q.soft_reset
                     |=> s_q.rx.slc_c == $past(slc_c_bits) && s_q.rx.slc_seen)
        else $error("SLC-96 fields not captured");

endmodule

`default_nettype wire
